// >>> rtl/ntscv_pkg.sv
// shared types and constants of the ntsc vertical line-rate converter
package ntscv_pkg;
   typedef enum logic [1:0] {
      NTSCV_DEC_CIF = 2'b00,
      NTSCV_DEC_QCIF = 2'b01,
      NTSCV_INT_CIF = 2'b10,
      NTSCV_INT_QCIF = 2'b11
   } ntscv_mode_t;
   // stream and buffer shape
   localparam int NTSCV_PIX_W = 16;
   localparam int NTSCV_WORD_W = 17;
   localparam int NTSCV_FIFO_D = 16;
   localparam int NTSCV_SET_W = 5;
   localparam int NTSCV_SRC_W = 4;
   // line group lengths per mode, drop and half phases, chroma set count, field offsets
   localparam logic [3:0] NTSCV_GRP_DCIF = 4'h5;
   localparam logic [3:0] NTSCV_GRP_QCIF = 4'ha;
   localparam logic [3:0] NTSCV_GRP_ICIF = 4'h6;
   localparam logic [3:0] NTSCV_DROP_PHASE = 4'h5;
   localparam logic [3:0] NTSCV_HALF_QCIF = 4'h5;
   localparam logic [1:0] NTSCV_CSETS_DEC = 2'h3;
   localparam logic [4:0] NTSCV_FIELD_OFS5 = 5'h05;
   localparam logic [4:0] NTSCV_FIELD_OFS10 = 5'h0a;
   // keep masks, bit n belongs to group phase n
   localparam logic [4:0] NTSCV_CK_DCIF = 5'h0b;
   localparam logic [9:0] NTSCV_QY_KEEP = 10'h16b;
   localparam logic [9:0] NTSCV_QC_KEEP = 10'h091;
   // qcif interpolation source line per output phase, nibble n for phase n
   localparam logic [39:0] NTSCV_QY_SRC = 40'h5544_3221_10;
   localparam logic [39:0] NTSCV_QC_SRC = 40'h2221_1110_00;
   // line totals
   localparam logic [9:0] NTSCV_CIF_Y_LINES = 10'h120;
   localparam logic [9:0] NTSCV_CIF_C_LINES = 10'h090;
   localparam logic [9:0] NTSCV_NTSC_C_FRAME = 10'h1e0;
   // line pacing, times in ns
   localparam int NTSCV_CLK_NS = 20;
   localparam int NTSCV_LINE_NS = 63556;
   localparam int NTSCV_NORM_CYC = NTSCV_LINE_NS / NTSCV_CLK_NS;
   localparam int NTSCV_FAST_CYC = (NTSCV_LINE_NS * 5) / (6 * NTSCV_CLK_NS);
   localparam logic [11:0] NTSCV_NORM_CNT = 12'(NTSCV_NORM_CYC - 1);
   localparam logic [11:0] NTSCV_FAST_CNT = 12'(NTSCV_FAST_CYC - 1);
endpackage

// >>> rtl/ntscv_fifo_if.sv
// handshake bundle between the sequencer and its line buffer
`timescale 1ns/1ps
interface ntscv_fifo_if #(parameter int W = 17, parameter int D = 16);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;
   logic [$clog2(D):0] count;
   modport fill (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data, count);
   modport store (input push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data, count);
endinterface

// >>> rtl/ntscv_fifo.sv
// parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module ntscv_fifo #(parameter int W = 17, parameter int D = 16) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // handshake bundle
   ntscv_fifo_if.store f
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem_q [D];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic do_push;
   logic do_pop;

   // honest full and empty from the fill count
   assign f.push_ready = (cnt_q != (AW+1)'(D));
   assign f.pop_valid = (cnt_q != '0);
   assign f.pop_data = mem_q[rd_q];
   assign f.count = cnt_q;
   assign do_push = ce && f.push_valid && f.push_ready;
   assign do_pop = ce && f.pop_valid && f.pop_ready;

   // one storage word per entry
   for (genvar i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            mem_q[i] <= '0;
         end else if (do_push && wr_q == AW'(i)) begin
            mem_q[i] <= f.push_data;
         end
      end
   end

   // write pointer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
      end else if (do_push) begin
         wr_q <= (wr_q == AW'(D - 1)) ? '0 : AW'(wr_q + 1'b1);
      end
   end

   // read pointer
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_q <= '0;
      end else if (do_pop) begin
         rd_q <= (rd_q == AW'(D - 1)) ? '0 : AW'(rd_q + 1'b1);
      end
   end

   // fill count
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt_q <= '0;
      end else if (do_push && !do_pop) begin
         cnt_q <= (AW+1)'(cnt_q + 1'b1);
      end else if (do_pop && !do_push) begin
         cnt_q <= (AW+1)'(cnt_q - 1'b1);
      end
   end
endmodule

// >>> rtl/ntscv_seq.sv
// ntsc vertical line-rate sequencer with line fifo and filter-line descriptors
`timescale 1ns/1ps
module ntscv_seq
   import ntscv_pkg::*;
(
   // clock, reset, enable
   input wire logic clk,
   input wire logic resetn,
   input wire logic ce,
   // configuration and field timing
   input wire ntscv_pkg::ntscv_mode_t mode,
   input wire logic field_start,
   input wire logic field_odd,
   // pixel stream in
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [ntscv_pkg::NTSCV_PIX_W-1:0] in_data,
   input wire logic in_sol,
   // pixel stream out
   output logic out_valid,
   input wire logic out_ready,
   output logic [ntscv_pkg::NTSCV_PIX_W-1:0] out_data,
   output logic out_sol,
   // filter-line descriptor
   output logic cmd_valid,
   output logic [ntscv_pkg::NTSCV_SET_W-1:0] cmd_luma_set,
   output logic [ntscv_pkg::NTSCV_SET_W-1:0] cmd_chroma_set,
   output logic cmd_luma_keep,
   output logic cmd_chroma_keep,
   output logic cmd_repeat,
   output logic cmd_chroma_reread,
   output logic [ntscv_pkg::NTSCV_SRC_W-1:0] cmd_luma_src,
   output logic [ntscv_pkg::NTSCV_SRC_W-1:0] cmd_chroma_src,
   // line pacing and status
   output logic fast_read,
   output logic pace_fast,
   output logic pace_norm,
   output logic [9:0] luma_lines,
   output logic [9:0] chroma_lines
);
   ntscv_fifo_if #(.W(NTSCV_WORD_W), .D(NTSCV_FIFO_D)) lf ();

   logic in_ready_q, out_valid_q, out_sol_q, rep_pend_q, drop_q, fodd_q;
   logic fast_read_q, pace_fast_q, pace_norm_q, cmd_valid_q;
   logic cmd_ykeep_q, cmd_ckeep_q, cmd_rep_q, cmd_reread_q;
   logic [NTSCV_PIX_W-1:0] out_data_q;
   logic [3:0] phase_q;
   logic [1:0] ck_q;
   logic [9:0] y_cnt_q, c_cnt_q;
   logic [11:0] fast_cnt_q, norm_cnt_q;
   logic [NTSCV_SET_W-1:0] cmd_yset_q, cmd_cset_q;
   logic [NTSCV_SRC_W-1:0] cmd_ysrc_q, cmd_csrc_q;

   logic fm, acc_in, step, issue, drop_word, out_free, out_valid_d, in_ready_d;
   logic d_ykeep, d_ckeep, d_rep, d_reread;
   logic [3:0] grp, ph5;
   logic [4:0] fofs;
   logic [NTSCV_SET_W-1:0] d_yset, d_cset;
   logic [NTSCV_SRC_W-1:0] d_ysrc, d_csrc;

   ntscv_fifo #(.W(NTSCV_WORD_W), .D(NTSCV_FIFO_D)) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .ce(ce),
      .f(lf.store)
   );

   // fifo sits in the path only for the cif modes
   assign fm = (mode == NTSCV_DEC_CIF) || (mode == NTSCV_INT_CIF);
   assign acc_in = in_valid && in_ready_q;
   assign step = acc_in && in_sol;
   assign issue = step || rep_pend_q;
   // words of the unused sixth line are taken but never written
   assign drop_word = in_sol ? (mode == NTSCV_INT_CIF && phase_q == NTSCV_DROP_PHASE)
                             : drop_q;
   assign lf.push_valid = fm && acc_in && !drop_word;
   assign lf.push_data = {in_sol, in_data};
   assign out_free = !out_valid_q || out_ready;
   assign lf.pop_ready = fm && out_free;
   assign ph5 = (phase_q >= NTSCV_HALF_QCIF) ? 4'(phase_q - NTSCV_HALF_QCIF) : phase_q;
   assign fofs = fodd_q ? NTSCV_FIELD_OFS5 : 5'h00;

   // group length per mode
   always_comb begin
      case (mode)
         NTSCV_DEC_CIF: grp = NTSCV_GRP_DCIF;
         NTSCV_INT_CIF: grp = NTSCV_GRP_ICIF;
         default: grp = NTSCV_GRP_QCIF;
      endcase
   end

   // descriptor of the filter line being issued
   always_comb begin
      d_yset = '0;
      d_cset = '0;
      d_ykeep = 1'b1;
      d_ckeep = 1'b1;
      d_rep = 1'b0;
      d_reread = 1'b0;
      d_ysrc = phase_q;
      d_csrc = phase_q;
      case (mode)
         NTSCV_DEC_CIF: begin
            d_rep = rep_pend_q;
            if (rep_pend_q) begin
               d_yset = 5'h01;
               d_ysrc = 4'h0;
               d_csrc = 4'h0;
               d_ckeep = 1'b0;
            end else begin
               d_yset = (phase_q == 4'h0) ? 5'h00 : 5'(phase_q + 4'h1);
               d_ckeep = NTSCV_CK_DCIF[phase_q[2:0]];
            end
            d_cset = 5'(ck_q);
         end
         NTSCV_DEC_QCIF: begin
            d_ykeep = NTSCV_QY_KEEP[phase_q];
            d_ckeep = NTSCV_QC_KEEP[phase_q];
            d_cset = 5'(ck_q);
         end
         NTSCV_INT_CIF: begin
            d_ykeep = (phase_q != NTSCV_DROP_PHASE);
            d_ckeep = (phase_q != NTSCV_DROP_PHASE);
            d_yset = 5'(5'(phase_q) + fofs);
            d_cset = 5'(5'(phase_q) + fofs);
            d_reread = phase_q[0];
            d_csrc = {1'b0, phase_q[3:1]};
         end
         NTSCV_INT_QCIF: begin
            d_yset = 5'(5'(ph5) + fofs);
            d_cset = 5'(5'(phase_q) + (fodd_q ? NTSCV_FIELD_OFS10 : 5'h00));
            d_ysrc = NTSCV_QY_SRC[{phase_q, 2'b00} +: 4];
            d_csrc = NTSCV_QC_SRC[{phase_q, 2'b00} +: 4];
         end
         default: d_yset = '0;
      endcase
   end

   // group phase, restarted per field
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= '0;
      end else if (ce) begin
         if (field_start) begin
            phase_q <= '0;
         end else if (step) begin
            phase_q <= (phase_q >= 4'(grp - 4'h1)) ? 4'h0 : 4'(phase_q + 4'h1);
         end
      end
   end

   // second presentation of the first line of a five-line group
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rep_pend_q <= 1'b0;
      end else if (ce) begin
         rep_pend_q <= !field_start && step && mode == NTSCV_DEC_CIF && phase_q == 4'h0;
      end
   end

   // chroma coefficient set among three kept outputs
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ck_q <= '0;
      end else if (ce) begin
         if (field_start) begin
            ck_q <= '0;
         end else if (issue && d_ckeep && !mode[1]) begin
            ck_q <= (ck_q == 2'(NTSCV_CSETS_DEC - 2'h1)) ? 2'h0 : 2'(ck_q + 2'h1);
         end
      end
   end

   // drop flag for the words of the unused line
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drop_q <= 1'b0;
      end else if (ce && acc_in && in_sol) begin
         drop_q <= drop_word;
      end
   end

   // field parity caught at field start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fodd_q <= 1'b0;
      end else if (ce && field_start) begin
         fodd_q <= field_odd;
      end
   end

   // kept-line counters, luma per field and chroma per frame
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         y_cnt_q <= '0;
         c_cnt_q <= '0;
      end else if (ce) begin
         if (field_start) begin
            y_cnt_q <= '0;
         end else if (issue && d_ykeep) begin
            y_cnt_q <= 10'(y_cnt_q + 10'h001);
         end
         if (field_start && !field_odd) begin
            c_cnt_q <= '0;
         end else if (issue && d_ckeep) begin
            c_cnt_q <= 10'(c_cnt_q + 10'h001);
         end
      end
   end

   // filter-line descriptor registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cmd_valid_q <= 1'b0;
         {cmd_yset_q, cmd_cset_q, cmd_ykeep_q, cmd_ckeep_q} <= '0;
         {cmd_rep_q, cmd_reread_q, cmd_ysrc_q, cmd_csrc_q} <= '0;
      end else if (ce) begin
         cmd_valid_q <= issue;
         if (issue) begin
            cmd_yset_q <= d_yset;
            cmd_cset_q <= d_cset;
            cmd_ykeep_q <= d_ykeep;
            cmd_ckeep_q <= d_ckeep;
            cmd_rep_q <= d_rep;
            cmd_reread_q <= d_reread;
            cmd_ysrc_q <= d_ysrc;
            cmd_csrc_q <= d_csrc;
         end
      end
   end

   // line pacers: reduced blanking and normal blanking
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fast_cnt_q <= NTSCV_FAST_CNT;
         norm_cnt_q <= NTSCV_NORM_CNT;
         {pace_fast_q, pace_norm_q, fast_read_q} <= 3'h0;
      end else if (ce) begin
         fast_read_q <= fm;
         if (field_start) begin
            fast_cnt_q <= NTSCV_FAST_CNT;
            norm_cnt_q <= NTSCV_NORM_CNT;
         end else begin
            fast_cnt_q <= (fast_cnt_q == 12'h000) ? NTSCV_FAST_CNT : 12'(fast_cnt_q - 12'h001);
            norm_cnt_q <= (norm_cnt_q == 12'h000) ? NTSCV_NORM_CNT : 12'(norm_cnt_q - 12'h001);
         end
         pace_fast_q <= fm && !field_start && fast_cnt_q == 12'h000;
         pace_norm_q <= !field_start && norm_cnt_q == 12'h000;
      end
   end

   // next state of the output stage and the input ready
   always_comb begin
      out_valid_d = out_valid_q;
      if (fm) begin
         if (lf.pop_valid && out_free) begin
            out_valid_d = 1'b1;
         end else if (out_ready) begin
            out_valid_d = 1'b0;
         end
      end else begin
         if (acc_in && out_free) begin
            out_valid_d = 1'b1;
         end else if (out_ready) begin
            out_valid_d = 1'b0;
         end
      end
      in_ready_d = fm ? (lf.count <= 5'(NTSCV_FIFO_D - 2)) : !out_valid_d;
   end

   // output stage and input ready registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         {out_valid_q, out_sol_q, in_ready_q} <= 3'h0;
         out_data_q <= '0;
      end else if (ce) begin
         out_valid_q <= out_valid_d;
         in_ready_q <= in_ready_d;
         if (fm && lf.pop_valid && out_free) begin
            out_data_q <= lf.pop_data[NTSCV_PIX_W-1:0];
            out_sol_q <= lf.pop_data[NTSCV_WORD_W-1];
         end else if (!fm && acc_in && out_free) begin
            out_data_q <= in_data;
            out_sol_q <= in_sol;
         end
      end
   end

   // outputs straight from their registers
   assign {in_ready, out_valid, out_sol} = {in_ready_q, out_valid_q, out_sol_q};
   assign out_data = out_data_q;
   assign {cmd_valid, cmd_luma_set, cmd_chroma_set} = {cmd_valid_q, cmd_yset_q, cmd_cset_q};
   assign {cmd_luma_keep, cmd_chroma_keep, cmd_repeat} = {cmd_ykeep_q, cmd_ckeep_q, cmd_rep_q};
   assign cmd_chroma_reread = cmd_reread_q;
   assign {cmd_luma_src, cmd_chroma_src} = {cmd_ysrc_q, cmd_csrc_q};
   assign {fast_read, pace_fast, pace_norm} = {fast_read_q, pace_fast_q, pace_norm_q};
   assign {luma_lines, chroma_lines} = {y_cnt_q, c_cnt_q};

   // checks on sequencing
   a_rep_first: assert property (@(posedge clk) disable iff (!resetn)
      ce && step && mode == NTSCV_DEC_CIF && phase_q == 4'h0 && !field_start
      |=> cmd_valid_q && !cmd_rep_q && cmd_yset_q == 5'h00 && rep_pend_q)
      else $error("first line of cif group not issued");
   a_rep_second: assert property (@(posedge clk) disable iff (!resetn)
      ce && rep_pend_q && mode == NTSCV_DEC_CIF && !field_start
      |=> cmd_valid_q && cmd_rep_q && cmd_yset_q == 5'h01 && cmd_ysrc_q == 4'h0)
      else $error("repeated cif line wrong");
   a_cif_ckeep: assert property (@(posedge clk) disable iff (!resetn)
      ce && step && mode == NTSCV_DEC_CIF && !rep_pend_q && !field_start
      |=> cmd_ckeep_q == NTSCV_CK_DCIF[$past(phase_q[2:0])])
      else $error("cif chroma keep pattern wrong");
   a_qcif_keep: assert property (@(posedge clk) disable iff (!resetn)
      ce && step && mode == NTSCV_DEC_QCIF && !field_start
      |=> cmd_ykeep_q == NTSCV_QY_KEEP[$past(phase_q)]
          && cmd_ckeep_q == NTSCV_QC_KEEP[$past(phase_q)])
      else $error("qcif keep pattern wrong");
   a_icif_drop: assert property (@(posedge clk) disable iff (!resetn)
      ce && step && mode == NTSCV_INT_CIF && phase_q == NTSCV_DROP_PHASE && !field_start
      |=> !cmd_ykeep_q && !cmd_ckeep_q)
      else $error("sixth cif line not dropped");
   a_icif_fset: assert property (@(posedge clk) disable iff (!resetn)
      ce && step && mode == NTSCV_INT_CIF && fodd_q && phase_q < 4'h5 && !field_start
      |=> cmd_yset_q == 5'(5'($past(phase_q)) + 5'h05))
      else $error("odd field luma set wrong");
   a_iqcif_src: assert property (@(posedge clk) disable iff (!resetn)
      ce && step && mode == NTSCV_INT_QCIF && phase_q == 4'h3 && !field_start
      |=> cmd_ysrc_q == 4'h2 && cmd_csrc_q == 4'h1)
      else $error("qcif source line wrong");
   a_bypass_fifo: assert property (@(posedge clk) disable iff (!resetn)
      ce && mode[0] && acc_in
      |=> out_valid_q && out_data_q == $past(in_data) && lf.count == '0)
      else $error("qcif mode did not bypass the fifo");
   a_field_restart: assert property (@(posedge clk) disable iff (!resetn)
      ce && field_start |=> phase_q == 4'h0 && ck_q == 2'h0 && !rep_pend_q)
      else $error("field start did not restart group");
   a_line_totals: assert property (@(posedge clk) disable iff (!resetn)
      (mode == NTSCV_DEC_CIF |-> y_cnt_q <= NTSCV_CIF_Y_LINES)
      and (mode == NTSCV_INT_CIF |-> c_cnt_q <= NTSCV_NTSC_C_FRAME))
      else $error("line total exceeded");
endmodule

// >>> verification/ntscv_video_end.sv
// video source and sink model on the sequencer pixel ports
`timescale 1ns/1ps
module ntscv_video_end
   import ntscv_pkg::*;
(
   // clock
   input wire logic clk,
   // source side
   output logic in_valid,
   input wire logic in_ready,
   output logic [ntscv_pkg::NTSCV_PIX_W-1:0] in_data,
   output logic in_sol,
   // sink side
   output logic out_ready
);
   logic stall;
   // idle source, prompt sink
   initial begin
      in_valid = 1'b0;
      in_data = '0;
      in_sol = 1'b0;
      stall = 1'b0;
   end
   // sink takes nothing while stalled
   assign out_ready = ~stall;
   // offer a word, hold until taken or lim tries pass, release with inverted data
   task automatic send_word(input logic [NTSCV_PIX_W-1:0] d, input logic sol, input int lim,
                            output bit ok);
      logic rdy;
      ok = 1'b0;
      @(posedge clk);
      in_valid <= 1'b1;
      in_data <= d;
      in_sol <= sol;
      for (int i = 0; i < lim && !ok; i++) begin
         @(negedge clk);
         rdy = in_ready;
         @(posedge clk);
         ok = rdy;
      end
      in_valid <= 1'b0;
      in_sol <= 1'b0;
      in_data <= ~d;
   endtask
endmodule

// >>> verification/ntscv_seq_tb.sv
// self-checking bench for the ntsc vertical line-rate sequencer
`timescale 1ns/1ps
module ntscv_seq_tb;
   import ntscv_pkg::*;
   logic clk, resetn, fs, odd, iv, ir, isol, ov, ordy, osol, cv, lk, ck, rep, rr, fr, pf, pn;
   ntscv_mode_t mode;
   logic [15:0] id, od;
   logic [4:0] lset, cset;
   logic [3:0] lsrc, csrc;
   logic [9:0] ll, cl;
   logic [21:0] cmds[$];
   logic [15:0] outs[$];
   int n_errors = 0;
   int n_tests = 0;
   bit ok;
   logic ce;
   int nsol = 0;
   ntscv_seq i_ntscv_seq(.clk(clk), .resetn(resetn), .ce(ce), .mode(mode), .field_start(fs),
      .field_odd(odd), .in_valid(iv), .in_ready(ir), .in_data(id), .in_sol(isol),
      .out_valid(ov), .out_ready(ordy), .out_data(od), .out_sol(osol), .cmd_valid(cv),
      .cmd_luma_set(lset), .cmd_chroma_set(cset), .cmd_luma_keep(lk), .cmd_chroma_keep(ck),
      .cmd_repeat(rep), .cmd_chroma_reread(rr), .cmd_luma_src(lsrc), .cmd_chroma_src(csrc),
      .fast_read(fr), .pace_fast(pf), .pace_norm(pn), .luma_lines(ll), .chroma_lines(cl));
   ntscv_video_end i_ntscv_video_end(.clk(clk), .in_valid(iv), .in_ready(ir), .in_data(id),
      .in_sol(isol), .out_ready(ordy));
   // free-running clock, 20 ns period
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // record descriptors and delivered words
   always @(posedge clk) begin
      if (cv === 1'b1) cmds.push_back({lset, cset, lk, ck, rep, rr, lsrc, csrc});
      if (ov === 1'b1 && ordy === 1'b1) outs.push_back(od);
      if (ov === 1'b1 && ordy === 1'b1 && osol === 1'b1) nsol++;
   end
   function automatic logic [21:0] mk(logic [4:0] a, logic [4:0] b, logic c, logic d,
                                      logic e, logic f, logic [3:0] g, logic [3:0] h);
      return {a, b, c, d, e, f, g, h};
   endfunction
   task automatic complete_run();
      if (n_errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   // compare masked fields of descriptor k
   task automatic cmdk(input int k, input logic [21:0] m, input logic [21:0] e);
      chk(32'(cmds.size() > k ? cmds[k] & m : 22'h3f_ffff), 32'(e));
   endtask
   task automatic fstart();
      fs <= 1'b1;
      @(posedge clk);
      fs <= 1'b0;
      @(posedge clk);
      cmds.delete();
      outs.delete();
      nsol = 0;
   endtask
   task automatic restart(input ntscv_mode_t m, input logic o);
      @(posedge clk);
      resetn <= 1'b0;
      mode <= m;
      odd <= o;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      fstart();
   endtask
   // one single-word line per step, spaced apart
   task automatic steps(input int n);
      for (int i = 0; i < n; i++) begin
         i_ntscv_video_end.send_word(16'(i), 1'b1, 200, ok);
         if (!ok) begin
            n_errors++;
            $display("MISMATCH at %0t: word never taken", $time);
            complete_run();
         end
         repeat (3) @(posedge clk);
      end
      repeat (60) @(posedge clk);
   endtask
   task automatic sc_dcif();
      restart(NTSCV_DEC_CIF, 1'b0);
      steps(5);
      chk(cmds.size(), 6);
      for (int k = 0; k < 6; k++) begin
         cmdk(k, mk('1, 0, 0, 1, 1, 0, 0, 0), mk(5'(k), 0, 0, k % 2 == 0, k == 1, 0, 0, 0));
      end
      chk(32'(ll), 6);
      chk(32'(cl), 3);
      chk(fr, 1);
      steps(2);
      fstart();
      steps(1);
      cmdk(1, mk('1, 0, 0, 0, 1, 0, 0, 0), mk(1, 0, 0, 0, 1, 0, 0, 0));
      chk(32'(ll), 2);
      ce <= 1'b0;
      i_ntscv_video_end.send_word(16'h0000, 1'b1, 4, ok);
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      chk(cmds.size(), 2);
      chk(32'(ll), 2);
   endtask
   task automatic sc_dqcif();
      restart(NTSCV_DEC_QCIF, 1'b0);
      steps(10);
      for (int k = 0; k < 10; k++) begin
         cmdk(k, mk(0, 0, 1, 1, 0, 0, 0, 0), mk(0, 0, 1'(10'h16b >> k), 1'(10'h091 >> k), 0, 0,
            0, 0));
         chk(outs.size() > k ? outs[k] : 16'hffff, k);
      end
      chk(32'(ll), 6);
      chk(32'(cl), 3);
      chk(fr, 0);
      chk(nsol, 10);
   endtask
   task automatic sc_icif();
      restart(NTSCV_INT_CIF, 1'b0);
      steps(6);
      for (int k = 0; k < 6; k++) begin
         cmdk(k, mk('1, 0, 1, 1, 0, 1, 0, '1), mk(5'(k), 0, k != 5, k != 5, 0, 1'(k % 2), 0,
            4'(k / 2)));
      end
      chk(outs.size(), 5);
      chk(32'(ll), 5);
      chk(fr, 1);
      for (int k = 0; k < outs.size(); k++) chk(outs[k], k);
      odd <= 1'b1;
      fstart();
      steps(1);
      cmdk(0, mk('1, '1, 0, 0, 0, 0, 0, 0), mk(5'h05, 5'h05, 0, 0, 0, 0, 0, 0));
   endtask
   task automatic sc_iqcif();
      restart(NTSCV_INT_QCIF, 1'b1);
      steps(10);
      for (int k = 0; k < 10; k++) begin
         cmdk(k, mk('1, '1, 0, 0, 0, 0, '1, '1), mk(5'(k % 5 + 5), 5'(k + 10), 0, 0, 0, 0,
            4'(40'h55_4432_2110 >> (4 * k)), 4'(40'h22_2111_1000 >> (4 * k))));
      end
      chk(outs.size(), 10);
      chk(32'(ll), 10);
   endtask
   // buffer filled against a stalled sink, then drained in order
   task automatic sc_fill();
      int n;
      n = 0;
      ok = 1'b1;
      restart(NTSCV_DEC_CIF, 1'b0);
      i_ntscv_video_end.stall <= 1'b1;
      while (ok && n < 20) begin
         i_ntscv_video_end.send_word(16'(n), n == 0, 30, ok);
         n += int'(ok);
      end
      chk(n >= 15 && n <= 17, 1);
      i_ntscv_video_end.stall <= 1'b0;
      repeat (60) @(posedge clk);
      chk(outs.size(), n);
      for (int k = 0; k < outs.size(); k++) chk(outs[k], k);
      chk(nsol, 1);
   endtask
   task automatic sc_pace();
      int tf[$];
      int tn[$];
      restart(NTSCV_DEC_CIF, 1'b0);
      for (int i = 0; i < 7000; i++) begin
         @(negedge clk);
         if (pf === 1'b1) tf.push_back(i);
         if (pn === 1'b1) tn.push_back(i);
      end
      chk(tf.size() > 1 ? tf[1] - tf[0] : 0, NTSCV_FAST_CYC);
      chk(tn.size() > 1 ? tn[1] - tn[0] : 0, NTSCV_NORM_CYC);
      restart(NTSCV_DEC_QCIF, 1'b0);
      tf.delete();
      for (int i = 0; i < 3000; i++) begin
         @(negedge clk);
         if (pf !== 1'b0) tf.push_back(i);
      end
      chk(tf.size(), 0);
   endtask
   // main sequence
   initial begin
      resetn = 1'b0;
      fs = 1'b0;
      odd = 1'b0;
      mode = NTSCV_DEC_CIF;
      ce = 1'b1;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      sc_dcif();
      sc_dqcif();
      sc_icif();
      sc_iqcif();
      sc_fill();
      sc_pace();
      complete_run();
   end
endmodule
